/* hdl/qic_core.sv */
// file: top of the encoder input conditioner with compare output and capture
`timescale 1ns/1ps
module qic_core
  import qic_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WRITE_I,
  input wire logic REG_READ_I,
  output logic [15:0] REG_RDATA_O,
  input wire logic PHASE_A_PIN_I,
  input wire logic PHASE_B_PIN_I,
  input wire logic MARKER_INPUT_PIN_I,
  input wire logic REFERENCE_INPUT_PIN_I,
  input wire logic [31:0] POSITION_COUNT_I,
  input wire logic MARKER_MATCH_I,
  input wire logic [2:0] COUNTER_INIT_MODE_I,
  output logic PHASE_A_O,
  output logic PHASE_B_O,
  output logic MARKER_O,
  output logic REFERENCE_O,
  output logic COMPARE_OUTPUT_PIN_O,
  output logic CAPTURE_STROBE_O,
  output logic IRQ_O
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [15:0] io_control;
  logic ref_flag;
  logic mark_flag;
  logic ref_ien;
  logic mark_ien;
  logic [31:0] le_value;
  logic [31:0] ge_value;
  logic [31:0] capture_value;
  logic [NUM_EVENTS-1:0] irq_status;
  logic [NUM_EVENTS-1:0] irq_enable;
  logic [NUM_EVENTS-1:0] event_hit;
  logic [6:0] div_cnt;
  logic [6:0] div_limit;
  logic filter_tick;
  logic [3:0] raw_inv;
  logic [3:0] filtered;
  logic [3:0] filtered_d;
  logic cmp_level;
  logic next_cmp;
  logic cmp_prev;
  logic capture_now;
  logic ref_event;
  logic mark_event;
  logic write_ioc;
  logic write_stat;
  logic flag_valid;
  logic [15:0] next_rdata;
  qic_cmp_mode_t cmp_mode;

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  // the bus never waits, so each strobe acts in its own cycle;
  // read and write strobes never come together
  assign write_ioc = REG_WRITE_I && REG_ADDR_I == ADDR_IO_CONTROL;
  assign write_stat = REG_WRITE_I && REG_ADDR_I == ADDR_EVENT_STATUS;
  assign cmp_mode = qic_cmp_mode_t'(io_control[IOC_MODE_LSB +: 2]);

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // level bits are never stored, only the writable upper part
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      io_control <= IOC_RESET;
    end else if (write_ioc) begin
      io_control <= REG_WDATA_I & IOC_RW_MASK;
    end
  end

  // compare thresholds, written in halves
  // halves are independent, so software writes both halves
  // of a new threshold before relying on the compare output;
  // a half-written value is compared until the other half is written
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      le_value <= 32'h0000_0000;
      ge_value <= 32'h0000_0000;
    end else if (REG_WRITE_I) begin
      if (REG_ADDR_I == ADDR_LE_CMP_LO) le_value[15:0] <= REG_WDATA_I;
      if (REG_ADDR_I == ADDR_LE_CMP_HI) le_value[31:16] <= REG_WDATA_I;
      if (REG_ADDR_I == ADDR_GE_CMP_LO) ge_value[15:0] <= REG_WDATA_I;
      if (REG_ADDR_I == ADDR_GE_CMP_HI) ge_value[31:16] <= REG_WDATA_I;
    end
  end

  // ---------------------------------------------------------------
  // filter clock divider
  // ---------------------------------------------------------------
  // ratio is 2^code, so limit is that minus one
  // one divider serves all four filters, so their ticks line up;
  // a code change to a limit below the current count only ends the current period early,
  // since the counter is compared with >= rather than ==
  assign div_limit = 7'((8'h01 << io_control[IOC_DIV_LSB +: 3]) - 8'h01);
  assign filter_tick = (div_cnt >= div_limit);

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      div_cnt <= 7'h00;
    end else if (filter_tick) begin
      div_cnt <= 7'h00;
    end else begin
      div_cnt <= div_cnt + 7'h01;
    end
  end

  // ---------------------------------------------------------------
  // polarity, filter and swap
  // ---------------------------------------------------------------
  // bit order: 3 reference, 2 marker, 1 phase b, 0 phase a
  // inversion comes first so the filter and the level bits both
  // see the polarity that software chose
  assign raw_inv = {REFERENCE_INPUT_PIN_I, MARKER_INPUT_PIN_I, PHASE_B_PIN_I, PHASE_A_PIN_I}
                   ^ io_control[IOC_INV_LSB +: 4];

  // one filter per input; the filters keep running while bypassed,
  // so enabling them never shows a stale level for long
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi = gi + 1) begin : g_filt
      qic_filter u_filter (
        .clk_i(CORE_CLK_I),
        .reset_n_i(RESET_N_I),
        .tick_i(filter_tick),
        .enable_i(io_control[IOC_FILTER_EN]),
        .raw_i(raw_inv[gi]),
        .level_o(filtered[gi])
      );
    end
  endgenerate

  // registered outputs toward the decoder, swap applied here
  // swap after the filter: the filters are identical, so the order
  // does not change the result, and the level bits stay unswapped
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      PHASE_A_O <= 1'b0;
      PHASE_B_O <= 1'b0;
      MARKER_O <= 1'b0;
      REFERENCE_O <= 1'b0;
    end else begin
      PHASE_A_O <= io_control[IOC_SWAP] ? filtered[1] : filtered[0];
      PHASE_B_O <= io_control[IOC_SWAP] ? filtered[0] : filtered[1];
      MARKER_O <= filtered[2];
      REFERENCE_O <= filtered[3];
    end
  end

  // ---------------------------------------------------------------
  // marker and reference events
  // ---------------------------------------------------------------
  // rising edge of the conditioned input is the event
  // events come from the filtered level, so a glitch that the filter
  // drops raises no flag and no interrupt
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      filtered_d <= 4'h0;
    end else begin
      filtered_d <= filtered;
    end
  end
  assign mark_event = filtered[2] & ~filtered_d[2];
  assign ref_event = filtered[3] & ~filtered_d[3];

  // flags: set wins over a same-cycle write-one-to-clear
  // an event lost to a clear would never be seen again,
  // while a flag that stays set is only read once more
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mark_flag <= 1'b0;
      ref_flag <= 1'b0;
    end else begin
      if (mark_event) mark_flag <= 1'b1;
      else if (write_stat && REG_WDATA_I[STAT_MARK_FLAG]) mark_flag <= 1'b0;
      if (ref_event) ref_flag <= 1'b1;
      else if (write_stat && REG_WDATA_I[STAT_REF_FLAG]) ref_flag <= 1'b0;
    end
  end

  // enable bits in the status register
  // these share the status write with the flag clears, so one
  // write both clears flags and sets the enables
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mark_ien <= 1'b0;
      ref_ien <= 1'b0;
    end else if (write_stat) begin
      mark_ien <= REG_WDATA_I[STAT_MARK_IEN];
      ref_ien <= REG_WDATA_I[STAT_REF_IEN];
    end
  end

  // reference flag only has meaning in two init modes
  // outside those modes it reads zero rather than a stale flag
  assign flag_valid = (COUNTER_INIT_MODE_I == INIT_MODE_FLAG_A)
                      || (COUNTER_INIT_MODE_I == INIT_MODE_FLAG_B);

  // ---------------------------------------------------------------
  // index capture
  // ---------------------------------------------------------------
  // capture follows the match pulse directly; the strobe tells
  // the counter side that a new value stands in the capture regs
  assign capture_now = io_control[IOC_CAPTURE_EN] & MARKER_MATCH_I;

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      capture_value <= 32'h0000_0000;
      CAPTURE_STROBE_O <= 1'b0;
    end else begin
      CAPTURE_STROBE_O <= capture_now;
      if (capture_now) capture_value <= POSITION_COUNT_I;
    end
  end

  // ---------------------------------------------------------------
  // compare output
  // ---------------------------------------------------------------
  // counts treated as signed, as a position is
  // mode 3 expects ge at or below le; with the values crossed the
  // window is empty and the output stays low
  always_comb begin
    unique case (cmp_mode)
      CMP_OFF: next_cmp = 1'b0;
      CMP_AT_OR_ABOVE: next_cmp = $signed(POSITION_COUNT_I) >= $signed(ge_value);
      CMP_AT_OR_BELOW: next_cmp = $signed(POSITION_COUNT_I) <= $signed(le_value);
      CMP_BETWEEN: next_cmp = ($signed(POSITION_COUNT_I) >= $signed(ge_value))
                              && ($signed(POSITION_COUNT_I) <= $signed(le_value));
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cmp_level <= 1'b0;
      cmp_prev <= 1'b0;
    end else begin
      cmp_level <= next_cmp;
      cmp_prev <= cmp_level;
    end
  end
  // the pin comes straight from a flip-flop, free of compare glitches;
  // the previous level feeds the rising-edge interrupt
  assign COMPARE_OUTPUT_PIN_O = cmp_level;

  // ---------------------------------------------------------------
  // interrupt status, clear and enable
  // ---------------------------------------------------------------
  // marker and reference also obey their own enables in status reg
  // capture and compare events have no enable of their own there,
  // so they always reach the sticky status bits
  assign event_hit[EV_MARKER] = mark_event & mark_ien;
  assign event_hit[EV_REFERENCE] = ref_event & ref_ien;
  assign event_hit[EV_CAPTURE] = capture_now;
  assign event_hit[EV_CMP_RISE] = cmp_level & ~cmp_prev;

  generate
    for (gi = 0; gi < NUM_EVENTS; gi = gi + 1) begin : g_irq
      always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
          irq_status[gi] <= 1'b0;
        end else if (event_hit[gi]) begin
          irq_status[gi] <= 1'b1; // set beats clear
        end else if (REG_WRITE_I && REG_ADDR_I == ADDR_IRQ_CLEAR && REG_WDATA_I[gi]) begin
          irq_status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // enable register: masks the interrupt pin only, never the status
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      irq_enable <= '0;
    end else if (REG_WRITE_I && REG_ADDR_I == ADDR_IRQ_ENABLE) begin
      irq_enable <= REG_WDATA_I[NUM_EVENTS-1:0];
    end
  end

  // level interrupt, combinational from registered state
  // a clear and a new event in one cycle keep the pin high
  assign IRQ_O = |(irq_status & irq_enable);

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // live levels are after inversion, before filter
  // reading them before the filter lets software see a noisy pin
  // that the filter is still holding back
  always_comb begin
    next_rdata = 16'h0000;
    unique case (REG_ADDR_I)
      ADDR_IO_CONTROL: next_rdata = io_control | {12'h000, raw_inv};
      ADDR_EVENT_STATUS: begin
        next_rdata[STAT_REF_FLAG] = ref_flag & flag_valid;
        next_rdata[STAT_REF_IEN] = ref_ien;
        next_rdata[STAT_MARK_FLAG] = mark_flag;
        next_rdata[STAT_MARK_IEN] = mark_ien;
      end
      ADDR_IRQ_STATUS: next_rdata[NUM_EVENTS-1:0] = irq_status;
      ADDR_IRQ_ENABLE: next_rdata[NUM_EVENTS-1:0] = irq_enable;
      ADDR_LE_CMP_LO: next_rdata = le_value[15:0];
      ADDR_LE_CMP_HI: next_rdata = le_value[31:16];
      ADDR_GE_CMP_LO: next_rdata = ge_value[15:0];
      ADDR_GE_CMP_HI: next_rdata = ge_value[31:16];
      ADDR_CAPTURE_LO: next_rdata = capture_value[15:0];
      ADDR_CAPTURE_HI: next_rdata = capture_value[31:16];
      default: next_rdata = 16'h0000; // unmapped and clear reg read zero
    endcase
  end

  // read data stand for one cycle only, then fall back to zero
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O <= 16'h0000;
    end else if (REG_READ_I) begin
      REG_RDATA_O <= next_rdata;
    end else begin
      REG_RDATA_O <= 16'h0000;
    end
  end
endmodule : qic_core

/* hdl/qic_pkg.sv */
// package: register map, field positions, reset values and codes for the input conditioner
package qic_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_IO_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_EVENT_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h3;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h4;
  localparam logic [3:0] ADDR_LE_CMP_LO = 4'h5;
  localparam logic [3:0] ADDR_LE_CMP_HI = 4'h6;
  localparam logic [3:0] ADDR_GE_CMP_LO = 4'h7;
  localparam logic [3:0] ADDR_GE_CMP_HI = 4'h8;
  localparam logic [3:0] ADDR_CAPTURE_LO = 4'h9;
  localparam logic [3:0] ADDR_CAPTURE_HI = 4'hA;
  // ---------------------------------------------------------------
  // io control fields
  // ---------------------------------------------------------------
  localparam int IOC_CAPTURE_EN = 15;
  localparam int IOC_FILTER_EN = 14;
  localparam int IOC_DIV_LSB = 11;
  localparam int IOC_MODE_LSB = 9;
  localparam int IOC_SWAP = 8;
  localparam int IOC_INV_LSB = 4;
  localparam int IOC_LEVEL_LSB = 0;
  localparam logic [15:0] IOC_RW_MASK = 16'hFFF0;
  localparam logic [15:0] IOC_RESET = 16'h0000;
  // ---------------------------------------------------------------
  // event status fields
  // ---------------------------------------------------------------
  localparam int STAT_REF_FLAG = 3;
  localparam int STAT_REF_IEN = 2;
  localparam int STAT_MARK_FLAG = 1;
  localparam int STAT_MARK_IEN = 0;
  localparam logic [15:0] STAT_RESET = 16'h0000;
  // ---------------------------------------------------------------
  // interrupt event bits
  // ---------------------------------------------------------------
  localparam int EV_MARKER = 0;
  localparam int EV_REFERENCE = 1;
  localparam int EV_CAPTURE = 2;
  localparam int EV_CMP_RISE = 3;
  localparam int NUM_EVENTS = 4;
  // ---------------------------------------------------------------
  // filter and mode constants
  // ---------------------------------------------------------------
  localparam logic [1:0] FILTER_STABLE_TICKS = 2'h3;
  localparam int NUM_INPUTS = 4;
  localparam logic [2:0] INIT_MODE_FLAG_A = 3'h3;
  localparam logic [2:0] INIT_MODE_FLAG_B = 3'h4;
  typedef enum logic [1:0] {
    CMP_OFF = 2'b00,
    CMP_AT_OR_ABOVE = 2'b01,
    CMP_AT_OR_BELOW = 2'b10,
    CMP_BETWEEN = 2'b11
  } qic_cmp_mode_t;
endpackage : qic_pkg

/* hdl/qic_filter.sv */
// file: digital glitch filter for one conditioned encoder input
`timescale 1ns/1ps
module qic_filter
  import qic_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic tick_i,
  input wire logic enable_i,
  input wire logic raw_i,
  output logic level_o
);
  logic held;
  logic candidate;
  logic [1:0] stable_cnt;

  // ---------------------------------------------------------------
  // stability counter
  // ---------------------------------------------------------------
  // new level accepted after three stable divided ticks
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      held <= 1'b0;
      candidate <= 1'b0;
      stable_cnt <= 2'h0;
    end else if (raw_i != candidate) begin
      candidate <= raw_i; // restart on any change
      stable_cnt <= 2'h0;
    end else if (tick_i && raw_i != held) begin
      if (stable_cnt == FILTER_STABLE_TICKS - 2'h1) begin
        held <= candidate;
        stable_cnt <= 2'h0;
      end else begin
        stable_cnt <= stable_cnt + 2'h1;
      end
    end
  end

  // bypass keeps the raw level when filter disabled
  assign level_o = enable_i ? held : raw_i;
endmodule : qic_filter

/* sim/qic_enc_model.sv */
// encoder stand-in driving the four input pins
`timescale 1ns/1ps
module qic_enc_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic mark_i,
  input wire logic ref_i,
  output logic a_o,
  output logic b_o,
  output logic marker_o,
  output logic reference_o
);
  logic [1:0] ph;
  // gray phase: one line moves per step, so no false edges
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph <= 2'h0;
      marker_o <= 1'b0;
      reference_o <= 1'b0;
    end else begin
      if (step_i) ph <= dir_i ? ph + 2'h1 : ph - 2'h1;
      marker_o <= mark_i;
      reference_o <= ref_i;
    end
  end
  assign a_o = ph[1];
  assign b_o = ph[1] ^ ph[0];
endmodule : qic_enc_model

/* sim/qic_core_monitor.sv */
// checker bound to the input conditioner top
`timescale 1ns/1ps
module qic_core_monitor
  import qic_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WRITE_I,
  input wire logic REG_READ_I,
  input wire logic [15:0] REG_RDATA_O,
  input wire logic PHASE_A_PIN_I,
  input wire logic PHASE_B_PIN_I,
  input wire logic MARKER_INPUT_PIN_I,
  input wire logic REFERENCE_INPUT_PIN_I,
  input wire logic [31:0] POSITION_COUNT_I,
  input wire logic MARKER_MATCH_I,
  input wire logic PHASE_A_O,
  input wire logic PHASE_B_O,
  input wire logic MARKER_O,
  input wire logic REFERENCE_O,
  input wire logic COMPARE_OUTPUT_PIN_O,
  input wire logic CAPTURE_STROBE_O,
  input wire logic IRQ_O
);
  logic [15:0] ioc;
  logic [3:0] ien;
  logic signed [31:0] le, ge, ps;
  logic ca, cb, mc, cx;
  // ----------------------------------------
  // register shadows
  // ----------------------------------------
  // mirror writes so outputs can be tied to settings
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ioc <= 16'h0000;
      ien <= 4'h0;
      le <= 32'h0;
      ge <= 32'h0;
    end else if (REG_WRITE_I) begin
      case (REG_ADDR_I)
        ADDR_IO_CONTROL: ioc <= REG_WDATA_I & IOC_RW_MASK;
        ADDR_IRQ_ENABLE: ien <= REG_WDATA_I[3:0];
        ADDR_LE_CMP_LO: le[15:0] <= REG_WDATA_I;
        ADDR_LE_CMP_HI: le[31:16] <= REG_WDATA_I;
        ADDR_GE_CMP_LO: ge[15:0] <= REG_WDATA_I;
        ADDR_GE_CMP_HI: ge[31:16] <= REG_WDATA_I;
        default: ;
      endcase
    end
  end
  // levels after inversion and the expected compare level
  assign ca = PHASE_A_PIN_I ^ ioc[4];
  assign cb = PHASE_B_PIN_I ^ ioc[5];
  assign mc = MARKER_INPUT_PIN_I ^ ioc[6];
  assign ps = POSITION_COUNT_I;
  always_comb begin
    case (ioc[10:9])
      CMP_AT_OR_ABOVE: cx = ps >= ge;
      CMP_AT_OR_BELOW: cx = ps <= le;
      CMP_BETWEEN: cx = ps >= ge && ps <= le;
      default: cx = 1'b0;
    endcase
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking dc @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  cap_on_match_a: assert property (MARKER_MATCH_I && ioc[15] |=> CAPTURE_STROBE_O)
    else $error("capture strobe missing");
  cap_quiet_a: assert property (!(MARKER_MATCH_I && ioc[15]) |=> !CAPTURE_STROBE_O)
    else $error("capture strobe without cause");
  phase_bypass_a: assert property ($past(RESET_N_I) && !$past(ioc[14]) |->
    {PHASE_A_O, PHASE_B_O} == $past(ioc[8] ? {cb, ca} : {ca, cb})) else $error("phase level wrong");
  mark_bypass_a: assert property ($past(RESET_N_I) && !$past(ioc[14]) |->
    {REFERENCE_O, MARKER_O} == $past({REFERENCE_INPUT_PIN_I ^ ioc[7], mc}))
    else $error("marker level wrong");
  cmp_follow_a: assert property ($past(RESET_N_I) |-> COMPARE_OUTPUT_PIN_O == $past(cx))
    else $error("compare output wrong");
  irq_gated_a: assert property (IRQ_O |-> ien != 4'h0)
    else $error("interrupt while disabled");
  ctl_readback_a: assert property (REG_READ_I && REG_ADDR_I == ADDR_IO_CONTROL |=>
    REG_RDATA_O[15:4] == $past(ioc[15:4])) else $error("control readback wrong");
  filter_hold_a: assert property ($rose(MARKER_O) && $past(ioc[14])
    && $past(ioc[14], 2) |-> $past(mc, 2) && $past(mc, 3) && $past(mc, 4))
    else $error("filter passed a glitch");
  cover property (CAPTURE_STROBE_O);
  cover property (COMPARE_OUTPUT_PIN_O && ioc[10:9] == 2'h3);
  cover property (IRQ_O);
endmodule : qic_core_monitor

bind qic_core qic_core_monitor u_mon (.CORE_CLK_I, .RESET_N_I, .REG_ADDR_I, .REG_WDATA_I,
  .REG_WRITE_I, .REG_READ_I, .REG_RDATA_O, .PHASE_A_PIN_I, .PHASE_B_PIN_I,
  .MARKER_INPUT_PIN_I, .REFERENCE_INPUT_PIN_I, .POSITION_COUNT_I, .MARKER_MATCH_I,
  .PHASE_A_O, .PHASE_B_O, .MARKER_O, .REFERENCE_O, .COMPARE_OUTPUT_PIN_O,
  .CAPTURE_STROBE_O, .IRQ_O);

/* sim/tb_top.sv */
// self-checking testbench for the input conditioner
`timescale 1ns/1ps
module tb_top;
  import qic_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic step = 1'b0;
  logic mk = 1'b0;
  logic rf = 1'b0;
  logic match = 1'b0;
  logic [2:0] imode = 3'h0;
  logic [31:0] pos = 32'h0;
  logic [31:0] capv;
  logic [15:0] rdata, rv, wv;
  logic [1:0] p = 2'h0;
  logic pa, pb, pm, pr, qa, qb, qm, qr, cmp, cap, irq, ea, eb, ex;
  int errors = 0;
  int checks_done = 0;
  int ge_v = -5;
  int le_v = 100;
  int tbl[5] = '{-10, -5, 50, 100, 101};
  always #20 clk = ~clk;
  qic_enc_model u_enc (.clk_i(clk), .rst_n_i(rst_n), .step_i(step), .dir_i(1'b1),
    .mark_i(mk), .ref_i(rf), .a_o(pa), .b_o(pb), .marker_o(pm), .reference_o(pr));
  qic_core DUT (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WRITE_I(wr_s), .REG_READ_I(rd_s), .REG_RDATA_O(rdata), .PHASE_A_PIN_I(pa),
    .PHASE_B_PIN_I(pb), .MARKER_INPUT_PIN_I(pm), .REFERENCE_INPUT_PIN_I(pr),
    .POSITION_COUNT_I(pos), .MARKER_MATCH_I(match), .COUNTER_INIT_MODE_I(imode),
    .PHASE_A_O(qa), .PHASE_B_O(qb), .MARKER_O(qm), .REFERENCE_O(qr),
    .COMPARE_OUTPUT_PIN_O(cmp), .CAPTURE_STROBE_O(cap), .IRQ_O(irq));
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 rv = rdata;
  endtask : rd
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // set pins, then wait past model and edge detect delay
  task automatic pin(input logic m, input logic r);
    @(posedge clk);
    mk <= m;
    rf <= r;
    cyc(4);
  endtask : pin
  task automatic complete_run();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'hcb01));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_IO_CONTROL);
    chk("ioc_rst", 32'h0, rv[15:4]);
    rd(ADDR_EVENT_STATUS);
    chk("stat_rst", 32'h0, rv);
    // every divider code with random other fields
    for (int c = 0; c < 8; c++) begin
      wv = 16'($urandom()) & 16'hC7F0 | 16'(c << 11);
      wr(ADDR_IO_CONTROL, wv);
      rd(ADDR_IO_CONTROL);
      chk("ioc_rw", wv, rv & 16'hFFF0);
    end
    rd(4'hF);
    chk("unmapped", 32'h0, rv);
    // all swap and invert combinations on moving pins
    for (int i = 0; i < 32; i++) begin
      wr(ADDR_IO_CONTROL, 16'(i << 4));
      @(posedge clk);
      step <= 1'b1;
      mk <= 1'($urandom());
      rf <= 1'($urandom());
      @(posedge clk);
      step <= 1'b0;
      p = p + 2'h1;
      cyc(3);
      ea = p[1] ^ i[0];
      eb = p[1] ^ p[0] ^ i[1];
      chk("phase", i[4] ? {eb, ea} : {ea, eb}, {qa, qb});
      chk("marks", {rf ^ i[3], mk ^ i[2]}, {qr, qm});
      rd(ADDR_IO_CONTROL);
      chk("levels", {rf ^ i[3], mk ^ i[2], eb, ea}, rv[3:0]);
    end
    // marker events, masking and clearing
    wr(ADDR_IO_CONTROL, 16'h0000);
    pin(1'b0, 1'b0);
    wr(ADDR_EVENT_STATUS, 16'h000A);
    wr(ADDR_IRQ_CLEAR, 16'h000F);
    wr(ADDR_IRQ_ENABLE, 16'h000F);
    pin(1'b1, 1'b0);
    rd(ADDR_EVENT_STATUS);
    chk("mark_flag", 32'h1, rv[1]);
    rd(ADDR_IRQ_STATUS);
    chk("mark_gated", 32'h0, {rv[0], irq});
    wr(ADDR_EVENT_STATUS, 16'h0003);
    pin(1'b0, 1'b0);
    pin(1'b1, 1'b0);
    chk("mark_irq", 32'h1, irq);
    wr(ADDR_IRQ_ENABLE, 16'h0000);
    chk("irq_mask", 32'h0, irq);
    wr(ADDR_IRQ_ENABLE, 16'h000F);
    chk("irq_unmask", 32'h1, irq);
    wr(ADDR_IRQ_CLEAR, 16'h0001);
    chk("irq_clear", 32'h0, irq);
    // reference event, flag seen only in two init modes
    wr(ADDR_EVENT_STATUS, 16'h0004);
    pin(1'b0, 1'b1);
    chk("ref_irq", 32'h1, irq);
    for (int m = 0; m < 8; m++) begin
      @(posedge clk);
      imode <= 3'(m);
      rd(ADDR_EVENT_STATUS);
      chk("ref_flag", 32'(m == 3 || m == 4), rv[3]);
    end
    wr(ADDR_IRQ_CLEAR, 16'h000F);
    wr(ADDR_EVENT_STATUS, 16'h0008);
    pin(1'b0, 1'b0);
    pin(1'b0, 1'b1);
    rd(ADDR_IRQ_STATUS);
    chk("ref_gated", 32'h0, {rv[1], irq});
    // capture enabled, then disabled: value must hold
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_IO_CONTROL, k ? 16'h0000 : 16'h8000);
      @(posedge clk);
      pos <= $urandom();
      match <= 1'b1;
      @(posedge clk);
      match <= 1'b0;
      #1 chk("cap_strobe", 32'(1 - k), cap);
      if (k == 0) capv = pos;
      rd(ADDR_CAPTURE_LO);
      chk("cap_lo", capv[15:0], rv);
      rd(ADDR_CAPTURE_HI);
      chk("cap_hi", capv[31:16], rv);
    end
    // each compare mode across the window boundaries
    wr(ADDR_GE_CMP_LO, ge_v[15:0]);
    wr(ADDR_GE_CMP_HI, ge_v[31:16]);
    wr(ADDR_LE_CMP_LO, le_v[15:0]);
    wr(ADDR_LE_CMP_HI, le_v[31:16]);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_IO_CONTROL, 16'(m << 9));
      foreach (tbl[j]) begin
        @(posedge clk);
        pos <= tbl[j];
        cyc(2);
        ex = m == 1 ? tbl[j] >= ge_v : m == 2 ? tbl[j] <= le_v :
          m == 3 ? tbl[j] >= ge_v && tbl[j] <= le_v : 1'b0;
        chk("compare", ex, cmp);
      end
    end
    // filter: glitch dropped, steady level taken late
    wr(ADDR_IO_CONTROL, 16'h4000);
    cyc(10);
    // one-cycle pulse: a bypass would show it at the next edge
    @(posedge clk);
    mk <= 1'b1;
    @(posedge clk);
    mk <= 1'b0;
    cyc(1);
    chk("glitch", 32'h0, qm);
    cyc(10);
    chk("glitch_end", 32'h0, qm);
    @(posedge clk);
    mk <= 1'b1;
    cyc(2);
    chk("early", 32'h0, qm);
    cyc(8);
    chk("steady", 32'h1, qm);
    wr(ADDR_IO_CONTROL, 16'h5800);
    @(posedge clk);
    mk <= 1'b0;
    cyc(6);
    chk("div_slow", 32'h1, qm);
    cyc(60);
    chk("div_done", 32'h0, qm);
    complete_run();
  end
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    complete_run();
  end
endmodule : tb_top
